// ==== design/lpst_pkg.sv ====
//----------------------------------------------------------------------
// lcd panel sync timing package
//----------------------------------------------------------------------
// Purpose: shared offsets, fields, reset values and states
// Assumes: 8-bit registers on a 9-bit byte address
// Notes:   one pixel per core_clk cycle
package lpst_pkg;
	// register offsets
	localparam logic [8:0] LPST_PANEL_CFG_ADDR  = 9'h030;
	localparam logic [8:0] LPST_HDISP_ADDR      = 9'h032;
	localparam logic [8:0] LPST_HBLANK_ADDR     = 9'h034;
	localparam logic [8:0] LPST_LSTART_ADDR     = 9'h035;
	localparam logic [8:0] LPST_LWIDTH_ADDR     = 9'h036;
	localparam logic [8:0] LPST_VHEIGHT_LO_ADDR = 9'h038;
	localparam logic [8:0] LPST_VHEIGHT_HI_ADDR = 9'h039;
	localparam logic [8:0] LPST_VBLANK_ADDR     = 9'h03a;
	localparam logic [8:0] LPST_FSTART_ADDR     = 9'h03b;
	localparam logic [8:0] LPST_FWIDTH_ADDR     = 9'h03c;
	localparam logic [8:0] LPST_DMODE_ADDR      = 9'h040;
	localparam logic [8:0] LPST_INT_STAT_ADDR   = 9'h050;
	localparam logic [8:0] LPST_INT_MASK_ADDR   = 9'h051;
	localparam logic [8:0] LPST_ROT0_ADDR       = 9'h1fc;
	// field positions
	localparam int LPST_TFT_BIT      = 0;
	localparam int LPST_POL_BIT      = 7;
	localparam int LPST_VSTAT_BIT    = 7;
	localparam int LPST_BLANK_BIT    = 7;
	localparam int LPST_ROT1_BIT     = 4;
	localparam int LPST_ROT0_BIT     = 6;
	localparam int LPST_INT_FRAME    = 0;
	localparam int LPST_INT_DISP     = 1;
	// pixel granularity of horizontal fields
	localparam int LPST_PX_SHIFT     = 3;
	localparam logic [10:0] LPST_LS_OFS_SHALLOW = 11'h004;
	localparam logic [10:0] LPST_LS_OFS_DEEP    = 11'h006;
	localparam logic [10:0] LPST_LS_PASSIVE_PX  = 11'h008;
	localparam int LPST_LS_MAX_PX    = 128;
	// colour depth codes
	localparam logic [2:0] LPST_BPP4  = 3'h2;
	localparam logic [2:0] LPST_BPP8  = 3'h3;
	localparam logic [2:0] LPST_BPP15 = 3'h4;
	localparam logic [2:0] LPST_BPP16 = 3'h5;
	// reset values
	localparam logic [7:0] LPST_REG_RST = 8'h00;
	// vertical phase
	typedef enum logic [1:0] {
		LPST_V_DISP  = 2'b01,
		LPST_V_BLANK = 2'b10
	} lpst_vstate_t;
endpackage

// ==== design/lpst_line_timer.sv ====
//----------------------------------------------------------------------
// horizontal line timer
//----------------------------------------------------------------------
// Purpose: pixel counter, line end pulse and line sync window
// Assumes: one pixel per clock
// Notes:   all outputs lag the counter by one cycle, uniformly
`timescale 1ns/10ps
`default_nettype none
module lpst_line_timer (
	input  wire logic        core_clk,     // pixel clock
	input  wire logic        sys_rst,      // sync reset, high
	input  wire logic [6:0]  hdisp,        // display width field
	input  wire logic [4:0]  hblank,       // non-display field
	input  wire logic [4:0]  ls_start,     // sync start field
	input  wire logic [3:0]  ls_width,     // sync width field
	input  wire logic        tft,          // active-matrix panel
	input  wire logic        deep_bpp,     // 15/16 bpp selected
	output logic             h_active,     // inside horizontal display
	output logic             line_end,     // last pixel of line, pulse
	output logic             ls_active     // line sync asserted (logical)
);
	logic [10:0] h_cnt_reg, h_cnt_next;
	logic        h_act_reg, h_act_next;
	logic        lend_reg, lend_next;
	logic        ls_reg, ls_next;
	logic [10:0] disp_px, total_px, s_px, e_px;
	logic [7:0]  run_reg, run_next;

	//----------------------------------------------------------------
	// counter and window decode
	//----------------------------------------------------------------
	// 11 bits covers 1024 display plus 256 blank pixels
	always_comb begin
		disp_px    = {({1'b0, hdisp} + 8'h01), 3'b000};
		total_px   = disp_px + {3'b000, ({1'b0, hblank} + 6'h01), 2'b00} * 11'h002;
		s_px       = disp_px + {3'b000, ls_start, 3'b000}
			+ (deep_bpp ? lpst_pkg::LPST_LS_OFS_DEEP : lpst_pkg::LPST_LS_OFS_SHALLOW);
		e_px       = s_px + {4'h0, ({1'b0, ls_width} + 5'h01), 2'b00} * 11'h002;
		lend_next  = (h_cnt_reg == total_px - 11'h001);
		h_cnt_next = lend_next ? 11'h000 : h_cnt_reg + 11'h001;
		h_act_next = (h_cnt_reg < disp_px);
		if (tft) begin
			ls_next = (h_cnt_reg >= s_px) && (h_cnt_reg < e_px);
		end else begin
			ls_next = (h_cnt_reg >= disp_px)
				&& (h_cnt_reg < disp_px + lpst_pkg::LPST_LS_PASSIVE_PX);
		end
		run_next = ls_reg ? run_reg + 8'h01 : 8'h00;
	end

	// register stage
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			h_cnt_reg <= 11'h000;
			h_act_reg <= 1'b0;
			lend_reg  <= 1'b0;
			ls_reg    <= 1'b0;
			run_reg   <= 8'h00;
		end else begin
			h_cnt_reg <= h_cnt_next;
			h_act_reg <= h_act_next;
			lend_reg  <= lend_next;
			ls_reg    <= ls_next;
			run_reg   <= run_next;
		end
	end

	assign h_active  = h_act_reg;
	assign line_end  = lend_reg;
	assign ls_active = ls_reg;

	// width field saturates at 128 pixels, so the pulse cannot run longer
	a_line_sync_max: assert property (@(posedge core_clk) disable iff (sys_rst)
		ls_reg |-> run_reg < 8'(lpst_pkg::LPST_LS_MAX_PX))
		else $error("line sync pulse longer than 128 pixels");

	a_line_end_single: assert property (@(posedge core_clk) disable iff (sys_rst)
		line_end |=> !line_end)
		else $error("line end pulse held for two cycles");
endmodule // lpst_line_timer
`default_nettype wire

// ==== design/lpst_timing.sv ====
//----------------------------------------------------------------------
// lcd panel sync timing
//----------------------------------------------------------------------
// Purpose: line/frame sync, vertical timing, blanking and mode outputs
// Assumes: one pixel per core_clk; registers are 8 bits wide
// Notes:   read data valid the cycle after the read strobe only
// Function
// - active-matrix line sync lasts (field+1)*8 pixels from a 4-bit field
// - line sync pulse never longer than 128 pixels
// - display shows 10-bit height plus one lines, split over two registers
// - status bit 7 reads 1 during vertical non-display, else 0
// - vertical non-display lasts 6-bit field plus one lines
// - active-matrix frame sync starts field plus one lines into blanking
// - frame sync polarity bit: 1 high on active-matrix, low on passive
// - active-matrix frame sync lasts 3-bit field plus one lines
// - blank bit disables pipeline and forces panel data to zero
// - rotation bit 1 rotates 180 degrees; with bit 0 picks four modes
// - colour depth codes 2..5 give 4, 8, 15, 16 bpp; 15/16 bypass table
// - panel type bit picks active-matrix timing at 1, passive at 0
// - line sync polarity bit behaves like frame sync polarity bit
`timescale 1ns/10ps
`default_nettype none
module lpst_timing #(
	parameter int DATA_W = 16                 // panel data width
) (
	input  wire logic              core_clk,      // pixel clock
	input  wire logic              sys_rst,       // sync reset, high
	input  wire logic [8:0]        reg_addr,      // register byte address
	input  wire logic [7:0]        reg_wdata,     // write data
	input  wire logic              reg_wr,        // write strobe
	input  wire logic              reg_rd,        // read strobe
	output logic      [7:0]        reg_rdata,     // read data, next cycle
	input  wire logic [DATA_W-1:0] pixel_in,      // pipeline pixel data
	output logic      [DATA_W-1:0] panel_data_out,// panel data
	output logic                   line_sync_out, // line sync pin
	output logic                   frame_sync_out,// frame sync pin
	output logic                   pipe_enable,   // display pipeline on
	output logic                   rotate_180,    // 180 degree rotation
	output logic      [1:0]        rotate_mode,   // {bit1, bit0} rotation
	output logic      [2:0]        bpp_sel,       // colour depth code
	output logic                   bpp_valid,     // code is not reserved
	output logic                   lut_bypass,    // 15/16 bpp
	output logic                   irq            // level interrupt
);
	// register file
	logic [7:0] panel_cfg_reg, panel_cfg_next;
	logic [7:0] hdisp_reg, hdisp_next;
	logic [7:0] hblank_reg, hblank_next;
	logic [7:0] lstart_reg, lstart_next;
	logic [7:0] lwidth_reg, lwidth_next;
	logic [7:0] vh_lo_reg, vh_lo_next;
	logic [7:0] vh_hi_reg, vh_hi_next;
	logic [7:0] vblank_reg, vblank_next;
	logic [7:0] fstart_reg, fstart_next;
	logic [7:0] fwidth_reg, fwidth_next;
	logic [7:0] dmode_reg, dmode_next;
	logic [7:0] rot0_reg, rot0_next;
	logic [1:0] istat_reg, istat_next;
	logic [1:0] imask_reg, imask_next;
	logic [7:0] rdata_reg, rdata_next;
	logic [7:0] rd_mux;
	// timing state
	lpst_pkg::lpst_vstate_t v_state_reg, v_state_next;
	logic [9:0]        v_cnt_reg, v_cnt_next;
	logic [1:0]        evt;
	// output stage
	logic [DATA_W-1:0] pdata_reg, pdata_next;
	logic              lso_reg, lso_next;
	logic              fso_reg, fso_next;
	logic              pen_reg, pen_next;
	logic              rot_reg, rot_next;
	logic [1:0]        rmode_reg, rmode_next;
	logic [2:0]        bpp_reg, bpp_next;
	logic              bval_reg, bval_next;
	logic              byp_reg, byp_next;
	logic              irq_reg, irq_next;
	// derived
	logic              tft, deep_bpp, blank, in_vblank, fs_act;
	logic              h_active, line_end, ls_active;
	logic [9:0]        height, fs_first, fs_last;

	assign tft       = panel_cfg_reg[lpst_pkg::LPST_TFT_BIT];
	assign blank     = dmode_reg[lpst_pkg::LPST_BLANK_BIT];
	assign deep_bpp  = (dmode_reg[2:0] == lpst_pkg::LPST_BPP15)
		|| (dmode_reg[2:0] == lpst_pkg::LPST_BPP16);
	assign height    = {vh_hi_reg[1:0], vh_lo_reg};
	assign in_vblank = (v_state_reg == lpst_pkg::LPST_V_BLANK);

	//----------------------------------------------------------------
	// horizontal timing
	//----------------------------------------------------------------
	lpst_line_timer u_line (
		.core_clk (core_clk),
		.sys_rst  (sys_rst),
		.hdisp    (hdisp_reg[6:0]),
		.hblank   (hblank_reg[4:0]),
		.ls_start (lstart_reg[4:0]),
		.ls_width (lwidth_reg[3:0]),
		.tft      (tft),
		.deep_bpp (deep_bpp),
		.h_active (h_active),
		.line_end (line_end),
		.ls_active(ls_active)
	);

	//----------------------------------------------------------------
	// register bus
	//----------------------------------------------------------------
	// read decode; unmapped addresses read zero
	always_comb begin
		case (reg_addr)
			lpst_pkg::LPST_PANEL_CFG_ADDR:  rd_mux = {7'h00, panel_cfg_reg[0]};
			lpst_pkg::LPST_HDISP_ADDR:      rd_mux = {1'b0, hdisp_reg[6:0]};
			lpst_pkg::LPST_HBLANK_ADDR:     rd_mux = {3'h0, hblank_reg[4:0]};
			lpst_pkg::LPST_LSTART_ADDR:     rd_mux = {3'h0, lstart_reg[4:0]};
			lpst_pkg::LPST_LWIDTH_ADDR:     rd_mux = {lwidth_reg[7], 3'h0, lwidth_reg[3:0]};
			lpst_pkg::LPST_VHEIGHT_LO_ADDR: rd_mux = vh_lo_reg;
			lpst_pkg::LPST_VHEIGHT_HI_ADDR: rd_mux = {6'h00, vh_hi_reg[1:0]};
			lpst_pkg::LPST_VBLANK_ADDR:     rd_mux = {in_vblank, 1'b0, vblank_reg[5:0]};
			lpst_pkg::LPST_FSTART_ADDR:     rd_mux = {2'h0, fstart_reg[5:0]};
			lpst_pkg::LPST_FWIDTH_ADDR:     rd_mux = {fwidth_reg[7], 4'h0, fwidth_reg[2:0]};
			lpst_pkg::LPST_DMODE_ADDR:      rd_mux = {dmode_reg[7], 2'h0, dmode_reg[4], 1'b0,
				dmode_reg[2:0]};
			lpst_pkg::LPST_INT_STAT_ADDR:   rd_mux = {6'h00, istat_reg};
			lpst_pkg::LPST_INT_MASK_ADDR:   rd_mux = {6'h00, imask_reg};
			lpst_pkg::LPST_ROT0_ADDR:       rd_mux = {1'b0, rot0_reg[6], 6'h00};
			default:                        rd_mux = 8'h00;
		endcase
	end

	// write decode, sticky status; a set in the clearing cycle wins
	always_comb begin
		panel_cfg_next = panel_cfg_reg;
		hdisp_next     = hdisp_reg;
		hblank_next    = hblank_reg;
		lstart_next    = lstart_reg;
		lwidth_next    = lwidth_reg;
		vh_lo_next     = vh_lo_reg;
		vh_hi_next     = vh_hi_reg;
		vblank_next    = vblank_reg;
		fstart_next    = fstart_reg;
		fwidth_next    = fwidth_reg;
		dmode_next     = dmode_reg;
		rot0_next      = rot0_reg;
		imask_next     = imask_reg;
		istat_next     = istat_reg;
		if (reg_wr) begin
			case (reg_addr)
				lpst_pkg::LPST_PANEL_CFG_ADDR:  panel_cfg_next = reg_wdata;
				lpst_pkg::LPST_HDISP_ADDR:      hdisp_next     = reg_wdata;
				lpst_pkg::LPST_HBLANK_ADDR:     hblank_next    = reg_wdata;
				lpst_pkg::LPST_LSTART_ADDR:     lstart_next    = reg_wdata;
				lpst_pkg::LPST_LWIDTH_ADDR:     lwidth_next    = reg_wdata;
				lpst_pkg::LPST_VHEIGHT_LO_ADDR: vh_lo_next     = reg_wdata;
				lpst_pkg::LPST_VHEIGHT_HI_ADDR: vh_hi_next     = reg_wdata;
				lpst_pkg::LPST_VBLANK_ADDR:     vblank_next    = {1'b0, reg_wdata[6:0]};
				lpst_pkg::LPST_FSTART_ADDR:     fstart_next    = reg_wdata;
				lpst_pkg::LPST_FWIDTH_ADDR:     fwidth_next    = reg_wdata;
				lpst_pkg::LPST_DMODE_ADDR:      dmode_next     = reg_wdata;
				lpst_pkg::LPST_ROT0_ADDR:       rot0_next      = reg_wdata;
				lpst_pkg::LPST_INT_MASK_ADDR:   imask_next     = reg_wdata[1:0];
				lpst_pkg::LPST_INT_STAT_ADDR:   istat_next     = istat_reg & ~reg_wdata[1:0];
				default:                        istat_next     = istat_reg;
			endcase
		end
		istat_next = istat_next | evt;
		rdata_next = reg_rd ? rd_mux : 8'h00;
	end

	// register file storage
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			panel_cfg_reg <= lpst_pkg::LPST_REG_RST;
			hdisp_reg     <= lpst_pkg::LPST_REG_RST;
			hblank_reg    <= lpst_pkg::LPST_REG_RST;
			lstart_reg    <= lpst_pkg::LPST_REG_RST;
			lwidth_reg    <= lpst_pkg::LPST_REG_RST;
			vh_lo_reg     <= lpst_pkg::LPST_REG_RST;
			vh_hi_reg     <= lpst_pkg::LPST_REG_RST;
			vblank_reg    <= lpst_pkg::LPST_REG_RST;
			fstart_reg    <= lpst_pkg::LPST_REG_RST;
			fwidth_reg    <= lpst_pkg::LPST_REG_RST;
			dmode_reg     <= lpst_pkg::LPST_REG_RST;
			rot0_reg      <= lpst_pkg::LPST_REG_RST;
			istat_reg     <= 2'h0;
			imask_reg     <= 2'h0;
			rdata_reg     <= 8'h00;
		end else begin
			panel_cfg_reg <= panel_cfg_next;
			hdisp_reg     <= hdisp_next;
			hblank_reg    <= hblank_next;
			lstart_reg    <= lstart_next;
			lwidth_reg    <= lwidth_next;
			vh_lo_reg     <= vh_lo_next;
			vh_hi_reg     <= vh_hi_next;
			vblank_reg    <= vblank_next;
			fstart_reg    <= fstart_next;
			fwidth_reg    <= fwidth_next;
			dmode_reg     <= dmode_next;
			rot0_reg      <= rot0_next;
			istat_reg     <= istat_next;
			imask_reg     <= imask_next;
			rdata_reg     <= rdata_next;
		end
	end

	//----------------------------------------------------------------
	// vertical timing
	//----------------------------------------------------------------
	// phases only change at line end, so a frame is whole lines
	always_comb begin
		v_state_next = v_state_reg;
		v_cnt_next   = v_cnt_reg;
		evt          = 2'h0;
		if (line_end) begin
			case (v_state_reg)
				lpst_pkg::LPST_V_DISP: begin
					if (v_cnt_reg >= height) begin
						v_state_next = lpst_pkg::LPST_V_BLANK;
						v_cnt_next   = 10'h000;
						evt[lpst_pkg::LPST_INT_FRAME] = 1'b1;
					end else begin
						v_cnt_next = v_cnt_reg + 10'h001;
					end
				end
				lpst_pkg::LPST_V_BLANK: begin
					if (v_cnt_reg >= {4'h0, vblank_reg[5:0]}) begin
						v_state_next = lpst_pkg::LPST_V_DISP;
						v_cnt_next   = 10'h000;
						evt[lpst_pkg::LPST_INT_DISP] = 1'b1;
					end else begin
						v_cnt_next = v_cnt_reg + 10'h001;
					end
				end
				default: begin
					v_state_next = lpst_pkg::LPST_V_DISP;
					v_cnt_next   = 10'h000;
				end
			endcase
		end
	end

	// vertical state storage
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			v_state_reg <= lpst_pkg::LPST_V_DISP;
			v_cnt_reg   <= 10'h000;
		end else begin
			v_state_reg <= v_state_next;
			v_cnt_reg   <= v_cnt_next;
		end
	end

	//----------------------------------------------------------------
	// output stage
	//----------------------------------------------------------------
	// frame sync window counted in blanking lines; passive uses first line
	assign fs_first = {4'h0, fstart_reg[5:0]} + 10'h001;
	assign fs_last  = fs_first + {7'h00, fwidth_reg[2:0]};
	assign fs_act   = in_vblank && (tft ? (v_cnt_reg >= fs_first && v_cnt_reg <= fs_last)
		: (v_cnt_reg == 10'h000));

	// polarity: bit set means high on active-matrix, low on passive
	always_comb begin
		lso_next   = ls_active ^ (tft ? ~lwidth_reg[lpst_pkg::LPST_POL_BIT]
			: lwidth_reg[lpst_pkg::LPST_POL_BIT]);
		fso_next   = fs_act ^ (tft ? ~fwidth_reg[lpst_pkg::LPST_POL_BIT]
			: fwidth_reg[lpst_pkg::LPST_POL_BIT]);
		pen_next   = ~blank;
		pdata_next = (blank || in_vblank || !h_active) ? '0 : pixel_in;
		rot_next   = dmode_reg[lpst_pkg::LPST_ROT1_BIT];
		rmode_next = {dmode_reg[lpst_pkg::LPST_ROT1_BIT], rot0_reg[lpst_pkg::LPST_ROT0_BIT]};
		bpp_next   = dmode_reg[2:0];
		bval_next  = (dmode_reg[2:0] >= lpst_pkg::LPST_BPP4)
			&& (dmode_reg[2:0] <= lpst_pkg::LPST_BPP16);
		byp_next   = deep_bpp;
		irq_next   = |(istat_reg & imask_reg);
	end

	// output flops
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			lso_reg   <= 1'b0;
			fso_reg   <= 1'b0;
			pen_reg   <= 1'b0;
			pdata_reg <= '0;
			rot_reg   <= 1'b0;
			rmode_reg <= 2'h0;
			bpp_reg   <= 3'h0;
			bval_reg  <= 1'b0;
			byp_reg   <= 1'b0;
			irq_reg   <= 1'b0;
		end else begin
			lso_reg   <= lso_next;
			fso_reg   <= fso_next;
			pen_reg   <= pen_next;
			pdata_reg <= pdata_next;
			rot_reg   <= rot_next;
			rmode_reg <= rmode_next;
			bpp_reg   <= bpp_next;
			bval_reg  <= bval_next;
			byp_reg   <= byp_next;
			irq_reg   <= irq_next;
		end
	end

	assign reg_rdata      = rdata_reg;
	assign panel_data_out = pdata_reg;
	assign line_sync_out  = lso_reg;
	assign frame_sync_out = fso_reg;
	assign pipe_enable    = pen_reg;
	assign rotate_180     = rot_reg;
	assign rotate_mode    = rmode_reg;
	assign bpp_sel        = bpp_reg;
	assign bpp_valid      = bval_reg;
	assign lut_bypass     = byp_reg;
	assign irq            = irq_reg;

	//----------------------------------------------------------------
	// checks
	//----------------------------------------------------------------
	a_blank_zero_data: assert property (@(posedge core_clk) disable iff (sys_rst)
		blank |=> (panel_data_out == '0) && !pipe_enable)
		else $error("blanked panel data not zero");

	a_status_reads_vblank: assert property (@(posedge core_clk) disable iff (sys_rst)
		reg_rd && reg_addr == lpst_pkg::LPST_VBLANK_ADDR |=> reg_rdata[7] == $past(in_vblank))
		else $error("vertical status bit wrong");

	a_height_to_blank: assert property (@(posedge core_clk) disable iff (sys_rst)
		line_end && !in_vblank && v_cnt_reg == height |=> in_vblank && v_cnt_reg == 10'h000)
		else $error("display phase length wrong");

	a_vblank_to_disp: assert property (@(posedge core_clk) disable iff (sys_rst)
		line_end && in_vblank && v_cnt_reg == {4'h0, vblank_reg[5:0]} |=> !in_vblank)
		else $error("non-display phase length wrong");

	a_fsync_idle_disp: assert property (@(posedge core_clk) disable iff (sys_rst)
		tft && !in_vblank && $stable(fwidth_reg) |=> frame_sync_out == !$past(fwidth_reg[7]))
		else $error("frame sync active during display");

	a_fsync_start_line: assert property (@(posedge core_clk) disable iff (sys_rst)
		tft && in_vblank && v_cnt_reg == fs_first && $stable(fwidth_reg)
		|=> frame_sync_out == $past(fwidth_reg[7]))
		else $error("frame sync not active at start line");

	a_rotate_follows: assert property (@(posedge core_clk) disable iff (sys_rst)
		dmode_reg[4] |=> rotate_180 && rotate_mode[1])
		else $error("rotation output not set");

	a_deep_bypass: assert property (@(posedge core_clk) disable iff (sys_rst)
		dmode_reg[2:0] == 3'h4 |=> lut_bypass && bpp_valid)
		else $error("15 bpp not bypassing table");

	a_irq_level: assert property (@(posedge core_clk) disable iff (sys_rst)
		|(istat_reg & imask_reg) |=> irq)
		else $error("interrupt not raised");
endmodule // lpst_timing
`default_nettype wire

// ==== verification/lpst_panel_model.sv ====
//----------------------------------------------------------------------
// panel side monitor
//----------------------------------------------------------------------
// Purpose: measures sync pulse lengths and frame period as a panel sees them
// Assumes: one pixel per clock; active level of each pin given by the bench
// Notes:   lengths in clock cycles; pulse lengths updated at trailing edges, frame period at leading edges
`timescale 1ns/10ps
`default_nettype none
module lpst_panel_model (
	input  wire logic core_clk,  // pixel clock
	input  wire logic sys_rst,   // sync reset, high
	input  wire logic ls,        // line sync pin
	input  wire logic fs,        // frame sync pin
	input  wire logic ls_hi,     // line sync active level
	input  wire logic fs_hi,     // frame sync active level
	output var  int   ls_len,    // last line pulse length
	output var  int   fs_len,    // last frame pulse length
	output var  int   frm_len    // leading edge to leading edge
);
	int   ls_run, fs_run, frm_run;
	logic ls_q, fs_q;
	// runs close on trailing edges; a level change mid-run gives one stale value
	always_ff @(posedge core_clk) begin
		ls_q <= ls;
		fs_q <= fs;
		ls_run <= (ls == ls_hi && !sys_rst) ? ls_run + 1 : 0;
		fs_run <= (fs == fs_hi && !sys_rst) ? fs_run + 1 : 0;
		frm_run <= (fs == fs_hi && fs_q != fs_hi) ? 1 : frm_run + 1;
		if (ls_q == ls_hi && ls != ls_hi) ls_len <= ls_run;
		if (fs_q == fs_hi && fs != fs_hi) fs_len <= fs_run;
		if (fs == fs_hi && fs_q != fs_hi) frm_len <= frm_run;
	end
endmodule // lpst_panel_model
`default_nettype wire

// ==== verification/tb_top.sv ====
//----------------------------------------------------------------------
// timing block testbench
//----------------------------------------------------------------------
// Purpose: register-level tests of sync timing, blanking and mode outputs
// Assumes: line 168 px (32 display, 136 blank), frame 4+6 lines
// Notes:   waits of 4000 cycles cover two full frames of 1680 cycles
`timescale 1ns/10ps
`default_nettype none
`define CHK(n,e,a) begin compares++; if ((a)!==(e)) begin fails++; $display("FAIL %s exp %h got %h", n, e, a); end end
module tb_top;
	logic        core_clk, sys_rst, reg_wr, reg_rd, ls_hi, fs_hi;
	logic [8:0]  reg_addr;
	logic [7:0]  reg_wdata, reg_rdata, d;
	logic [15:0] pixel_in, panel_data_out, acc;
	logic        line_sync_out, frame_sync_out, pipe_enable, rotate_180;
	logic        bpp_valid, lut_bypass, irq;
	logic [1:0]  rotate_mode;
	logic [2:0]  bpp_sel;
	int          ls_len, fs_len, frm_len, fails, compares, n;
	lpst_timing #(.DATA_W(16)) lpst_timing_inst (.core_clk(core_clk), .sys_rst(sys_rst),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .pixel_in(pixel_in), .panel_data_out(panel_data_out),
		.line_sync_out(line_sync_out), .frame_sync_out(frame_sync_out),
		.pipe_enable(pipe_enable), .rotate_180(rotate_180), .rotate_mode(rotate_mode),
		.bpp_sel(bpp_sel), .bpp_valid(bpp_valid), .lut_bypass(lut_bypass), .irq(irq));
	lpst_panel_model lpst_panel_model_inst (.core_clk(core_clk), .sys_rst(sys_rst),
		.ls(line_sync_out), .fs(frame_sync_out), .ls_hi(ls_hi), .fs_hi(fs_hi),
		.ls_len(ls_len), .fs_len(fs_len), .frm_len(frm_len));
	// free running pixel clock
	initial begin
		core_clk = 1'b0;
		forever #12.5 core_clk = ~core_clk;
	end
	// one strobe cycle, then one idle cycle so no signal is set twice in a step
	task wr(input logic [8:0] a, input logic [7:0] v);
		reg_addr <= a; reg_wdata <= v; reg_wr <= 1'b1;
		@(posedge core_clk) reg_wr <= 1'b0;
		@(posedge core_clk);
	endtask
	// read data stands only in the cycle after the strobe
	task rd(input logic [8:0] a);
		reg_addr <= a; reg_rd <= 1'b1;
		@(posedge core_clk) reg_rd <= 1'b0;
		#1 d = reg_rdata;
		@(posedge core_clk);
	endtask
	task print_verdict;
		$display("compares %0d fails %0d", compares, fails);
		if (fails == 0 && compares > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask
	// measure one panel setup after two frames settle
	task sync_case(input logic [7:0] cfg, pol, input int el, ef);
		wr(9'h030, cfg); wr(9'h036, {pol[7], 7'h0f}); wr(9'h03c, {pol[7], 7'h01});
		ls_hi <= pol[7] ~^ cfg[0]; fs_hi <= pol[7] ~^ cfg[0];
		repeat (4000) @(posedge core_clk);
		`CHK("line pulse", el, ls_len)
		`CHK("frame pulse", ef, fs_len)
		`CHK("frame period", 1680, frm_len)
	endtask
	// bounded poll of the vertical status bit
	task poll_stat(input logic v);
		d = 8'hxx;
		for (n = 0; n < 2000 && d[7] !== v; n++) rd(9'h03a);
		`CHK("vstat", v, d[7])
		if (d[7] !== v) print_verdict;
	endtask
	initial begin
		fails = 0; compares = 0; sys_rst = 1'b1; reg_wr = 1'b0; reg_rd = 1'b0;
		reg_addr = 9'h000; reg_wdata = 8'h00; pixel_in = 16'h5a5a; ls_hi = 1'b0; fs_hi = 1'b0;
		repeat (6) @(posedge core_clk);
		sys_rst <= 1'b0;
		@(posedge core_clk);
		rd(9'h040); `CHK("mode reset", 8'h00, d)
		wr(9'h032, 8'h03); wr(9'h034, 8'h10); wr(9'h035, 8'h00);
		wr(9'h038, 8'h03); wr(9'h039, 8'h03); rd(9'h039); `CHK("height hi", 8'h03, d)
		wr(9'h039, 8'h00); wr(9'h03b, 8'h01); wr(9'h03a, 8'h85);
		rd(9'h03a); `CHK("vblank field", 7'h05, d[6:0])
		rd(9'h0ff); `CHK("unmapped", 8'h00, d)
		$display("test registers done");
		sync_case(8'h01, 8'h80, 128, 336);
		sync_case(8'h01, 8'h00, 128, 336);
		sync_case(8'h00, 8'h80, 8, 168);
		$display("test sync done");
		poll_stat(1'b1); poll_stat(1'b0);
		wr(9'h051, 8'h01);
		for (n = 0; n < 4000 && irq !== 1'b1; n++) @(posedge core_clk);
		`CHK("irq raised", 1'b1, irq)
		if (irq !== 1'b1) print_verdict;
		wr(9'h051, 8'h00);
		#1 `CHK("irq masked", 1'b0, irq)
		rd(9'h050); `CHK("stat set", 1'b1, d[0])
		wr(9'h050, 8'h03); rd(9'h050); `CHK("stat clr", 1'b0, d[0])
		$display("test irq done");
		// rotation bit 0 alone, then bit 1 held in every mode below
		wr(9'h1fc, 8'h40); wr(9'h040, 8'h00);
		@(posedge core_clk) #1;
		`CHK("rot off", 1'b0, rotate_180)
		`CHK("rot mode 90", 2'b01, rotate_mode)
		for (n = 0; n < 16; n++) begin
			wr(9'h040, {4'h1, 1'b0, n[2:0]});
			@(posedge core_clk) #1;
			`CHK("bpp", n[2:0], bpp_sel)
			`CHK("bpp valid", (n[2:0] >= 3'h2 && n[2:0] <= 3'h5), bpp_valid)
			`CHK("lut bypass", (n[2:0] == 3'h4 || n[2:0] == 3'h5), lut_bypass)
			`CHK("rot", 1'b1, rotate_180)
			`CHK("rot mode", 2'b11, rotate_mode)
		end
		$display("test modes done");
		acc = 16'h0000;
		for (n = 0; n < 2000 && acc !== 16'h5a5a; n++) @(posedge core_clk) acc = panel_data_out;
		`CHK("data live", 16'h5a5a, acc)
		`CHK("pipe on", 1'b1, pipe_enable)
		wr(9'h041, 8'h01); wr(9'h040, 8'h80); @(posedge core_clk);
		acc = 16'h0000;
		// a whole frame, so display lines are covered whatever the phase
		for (n = 0; n < 1700; n++) @(posedge core_clk) acc = acc | panel_data_out;
		`CHK("blank data", 16'h0000, acc)
		`CHK("pipe off", 1'b0, pipe_enable)
		$display("test blank done");
		print_verdict;
	end
endmodule // tb_top
`default_nettype wire
